// ==== shared/msc_pkg.sv ====
// Constants and carrier types for the meter setting command decoder.
// Assumes commands arrive already split into letter and numeric value.
package msc_pkg;
  // Command letters, ASCII
  localparam logic [7:0] LTR_RANGE = 8'h52;
  localparam logic [7:0] LTR_ZERO = 8'h5A;
  localparam logic [7:0] LTR_FILT = 8'h50;
  localparam logic [7:0] LTR_RATE = 8'h53;
  localparam logic [7:0] LTR_VALUE = 8'h56;
  localparam logic [7:0] LTR_EXEC = 8'h58;
  // Legal code limits
  localparam logic [31:0] RANGE_MAX = 32'h0000_0007;
  localparam logic [31:0] ZERO_MAX = 32'h0000_0002;
  localparam logic [31:0] FILT_MAX = 32'h0000_0063;
  localparam logic [31:0] RATE_MAX = 32'h0000_0003;
  // Zero mode codes
  localparam logic [1:0] ZERO_OFF = 2'h0;
  localparam logic [1:0] ZERO_BASE = 2'h1;
  localparam logic [1:0] ZERO_PROG = 2'h2;
  // Reset values
  localparam logic [2:0] RANGE_AUTO = 3'h0;
  localparam logic [1:0] RATE_DEFAULT = 2'h3;
  localparam logic [6:0] FILT_CNT_DEFAULT = 7'h0A;
  // Function codes with special resolution rules
  localparam logic [2:0] FUNC_DCA = 3'h3;
  localparam logic [2:0] FUNC_ACA = 3'h4;
  localparam logic [2:0] FUNC_OHMS = 3'h2;
  localparam logic [2:0] FUNC_OCOHMS = 3'h7;
  localparam int NUM_FUNC = 8;
  // Integration periods in ns and the clock period
  localparam int CLK_PERIOD_NS = 10;
  localparam int INT_35_NS = 318000;
  localparam int INT_45_NS = 2590000;
  localparam int INT_50HZ_NS = 20000000;
  localparam int INT_60HZ_NS = 16600000;
  localparam int INT_35_CYC = INT_35_NS / CLK_PERIOD_NS;
  localparam int INT_45_CYC = INT_45_NS / CLK_PERIOD_NS;
  localparam int INT_50HZ_CYC = INT_50HZ_NS / CLK_PERIOD_NS;
  localparam int INT_60HZ_CYC = INT_60HZ_NS / CLK_PERIOD_NS;
  localparam int INT_W = 22;

  // Usable resolution
  typedef enum logic [1:0] {
    RES_35 = 2'b00,
    RES_45 = 2'b01,
    RES_55 = 2'b10,
    RES_65 = 2'b11
  } msc_res_type;

  // One parsed command from the bus
  typedef struct packed {
    logic valid;
    logic [7:0] letter;
    logic signed [31:0] value;
  } msc_cmd_type;

  // Applied settings
  typedef struct packed {
    logic [2:0] range;
    logic autorange;
    logic [1:0] zero_mode;
    logic filt_on;
    logic [1:0] rate;
  } msc_set_type;
endpackage

// ==== core/msc_filter_mem.sv ====
// Per-function filter count store, eight entries of seven bits.
// Assumes one write port and a registered read of the active entry.
module msc_filter_mem
  import msc_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Clear all entries to default
  input wire logic clr,
  // Write port
  input wire logic wr_en,
  input wire logic [2:0] wr_addr,
  input wire logic [6:0] wr_data,
  // Read port
  input wire logic [2:0] rd_addr,
  output logic [6:0] rd_data
);
  logic [6:0] mem_reg [NUM_FUNC]; // One count per function

  // Each entry cleared or written on its own
  genvar g;
  generate
    for (g = 0; g < NUM_FUNC; g++) begin : g_ent
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          mem_reg[g] <= FILT_CNT_DEFAULT;
        end else if (clr) begin
          mem_reg[g] <= FILT_CNT_DEFAULT;
        end else if (wr_en && wr_addr == 3'(g)) begin
          mem_reg[g] <= wr_data;
        end
      end
    end
  endgenerate

  // Registered read; a write shows one cycle later
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_data <= FILT_CNT_DEFAULT;
    end else begin
      rd_data <= mem_reg[rd_addr];
    end
  end
endmodule

// ==== core/msc_rate_table.sv ====
// Maps rate, function and range to resolution and integration period.
// Assumes the mains frequency flag is stable between changes.
module msc_rate_table
  import msc_pkg::*;
#(
  parameter int C35 = INT_35_CYC,
  parameter int C45 = INT_45_CYC,
  parameter int C50 = INT_50HZ_CYC,
  parameter int C60 = INT_60HZ_CYC
)
(
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Selection
  input wire logic [1:0] rate,
  input wire logic [2:0] func,
  input wire logic [2:0] range,
  input wire logic line_60hz,
  // Results, registered
  output msc_res_type res,
  output logic [INT_W-1:0] int_cycles
);
  msc_res_type res_next; // Resolution before the register
  logic [INT_W-1:0] cyc_next; // Period before the register
  logic hi_ohms; // Ohms ranges 5 to 7

  // Resolution per rate and function
  always_comb begin
    hi_ohms = (range >= 3'h5);
    res_next = msc_res_type'(rate); // Base: rate n gives n steps up
    if (func == FUNC_OHMS) begin
      if (rate == 2'h3) begin
        res_next = (range == 3'h7) ? RES_55 : RES_65;
      end else if (hi_ohms) begin
        res_next = RES_55; // High ohm ranges never below 5.5 digits
      end
    end else if (func == FUNC_DCA || func == FUNC_ACA) begin
      if (rate == 2'h3) begin
        res_next = RES_55; // Current tops out at 5.5 digits
      end
    end else if (func == FUNC_OCOHMS) begin
      res_next = (rate == 2'h3) ? RES_65 : RES_55;
    end else if (func == 3'h5 || func == 3'h6) begin
      res_next = RES_55; // dB functions fixed
    end
  end

  // Period follows resolution; line cycle depends on mains
  always_comb begin
    unique case (res_next)
      RES_35: cyc_next = INT_W'(C35);
      RES_45: cyc_next = INT_W'(C45);
      RES_55, RES_65: cyc_next = line_60hz ? INT_W'(C60) : INT_W'(C50);
    endcase
  end

  // Output registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      res <= RES_35;
      int_cycles <= INT_W'(C35);
    end else begin
      res <= res_next;
      int_cycles <= cyc_next;
    end
  end
endmodule

// ==== core/msc_decoder.sv ====
// Range, zero, filter and rate setting decoder with command buffer.
// Assumes an upstream parser delivering one letter and value per cycle,
// and a front end that pulses when a range change is complete.

module msc_decoder
  import msc_pkg::*;
#(
  parameter int INT_35_CYCLES = INT_35_CYC,
  parameter int INT_45_CYCLES = INT_45_CYC,
  parameter int INT_50HZ_CYCLES = INT_50HZ_CYC,
  parameter int INT_60HZ_CYCLES = INT_60HZ_CYC
)
(
  // Clock and reset
  input wire logic I_REF_CLK,
  input wire logic I_RST,
  // Bus side
  input wire msc_pkg::msc_cmd_type I_CMD,
  input wire logic I_REMOTE_EN,
  input wire logic I_DEV_CLEAR,
  // Measurement context
  input wire logic [2:0] I_FUNC,
  input wire logic I_LINE_60HZ,
  input wire logic I_RANGE_DONE,
  input wire logic signed [31:0] I_READING,
  input wire logic I_READING_VALID,
  // Applied settings
  output msc_pkg::msc_set_type O_SETTINGS,
  output logic [6:0] O_FILT_CNT,
  output msc_pkg::msc_res_type O_RESOLUTION,
  output logic [msc_pkg::INT_W-1:0] O_INT_CYCLES,
  output logic signed [31:0] O_ZERO_SLOT,
  // Status
  output logic O_READY,
  output logic O_CMD_ERR,
  output logic O_BUS_ERR,
  // Corrected reading
  output logic signed [31:0] O_READING,
  output logic O_READING_VALID
);
  import msc_pkg::*;

  // Pending command buffer
  logic pend_range_vld_reg; // Range code waiting
  logic [2:0] pend_range_reg;
  logic pend_zero_vld_reg; // Zero code waiting
  logic [1:0] pend_zero_reg;
  logic pend_filt_vld_reg; // Filter code waiting
  logic [6:0] pend_filt_reg;
  logic pend_rate_vld_reg; // Rate code waiting
  logic [1:0] pend_rate_reg;
  logic pend_v_vld_reg; // Offset value waiting
  logic signed [31:0] pend_v_reg;
  logic pend_err_reg; // Some buffered code was bad

  // Applied state
  msc_set_type set_reg; // Drives O_SETTINGS
  logic signed [31:0] offset_reg; // Programmed offset value
  logic v_set_reg; // An offset has been programmed
  logic signed [31:0] zero_ref_reg; // Value subtracted while zero on
  logic signed [31:0] last_rd_reg; // Most recent input reading
  logic ready_reg;
  logic cmd_err_reg;
  logic bus_err_reg;
  logic signed [31:0] rd_out_reg;
  logic rd_vld_reg;

  // Decode of the incoming command
  logic cmd_ok; // Command accepted from the bus
  logic is_exec; // Execute character
  logic apply; // Execute with clean buffer
  logic val_bad; // Value outside legal range for its letter
  logic [31:0] val_u; // Value as unsigned for range checks
  logic signed [31:0] new_offset; // Offset in force after this execute
  logic new_v_set;
  logic signed [31:0] present_rd; // Reading to take as baseline
  logic filt_wr; // Filter memory write strobe

  // Command gating: no remote enable, no command
  assign cmd_ok = I_CMD.valid && I_REMOTE_EN && !I_DEV_CLEAR;
  assign is_exec = cmd_ok && I_CMD.letter == LTR_EXEC;
  assign apply = is_exec && !pend_err_reg;
  assign val_u = I_CMD.value;

  // Range check per letter; negative range, zero, filter and rate codes are bad
  always_comb begin
    val_bad = I_CMD.value < 0;
    unique case (I_CMD.letter)
      LTR_RANGE: val_bad = val_bad || val_u > RANGE_MAX;
      LTR_ZERO: val_bad = val_bad || val_u > ZERO_MAX;
      LTR_FILT: val_bad = val_bad || val_u > FILT_MAX;
      LTR_RATE: val_bad = val_bad || val_u > RATE_MAX;
      default: val_bad = 1'b0; // Offset and other letters unchecked here
    endcase
  end

  // Offset in force, including one buffered with this execute
  assign new_offset = pend_v_vld_reg ? pend_v_reg : offset_reg;
  assign new_v_set = pend_v_vld_reg || v_set_reg;
  // Present reading, taking a same-cycle sample if there is one
  assign present_rd = I_READING_VALID ? I_READING : last_rd_reg;

  // Command buffer; execute or clear empties it
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      pend_range_vld_reg <= 1'b0;
      pend_range_reg <= RANGE_AUTO;
      pend_zero_vld_reg <= 1'b0;
      pend_zero_reg <= ZERO_OFF;
      pend_filt_vld_reg <= 1'b0;
      pend_filt_reg <= 7'h00;
      pend_rate_vld_reg <= 1'b0;
      pend_rate_reg <= RATE_DEFAULT;
      pend_v_vld_reg <= 1'b0;
      pend_v_reg <= 32'sh0000_0000;
      pend_err_reg <= 1'b0;
    end else if (I_DEV_CLEAR || is_exec) begin
      // Buffer dropped after execute, good or bad
      pend_range_vld_reg <= 1'b0;
      pend_zero_vld_reg <= 1'b0;
      pend_filt_vld_reg <= 1'b0;
      pend_rate_vld_reg <= 1'b0;
      pend_v_vld_reg <= 1'b0;
      pend_err_reg <= 1'b0;
    end else if (cmd_ok) begin
      if (val_bad) begin
        pend_err_reg <= 1'b1; // Poisons the whole string
      end else begin
        unique case (I_CMD.letter)
          LTR_RANGE: begin
            pend_range_vld_reg <= 1'b1;
            pend_range_reg <= I_CMD.value[2:0];
          end
          LTR_ZERO: begin
            pend_zero_vld_reg <= 1'b1;
            pend_zero_reg <= I_CMD.value[1:0];
          end
          LTR_FILT: begin
            pend_filt_vld_reg <= 1'b1;
            pend_filt_reg <= I_CMD.value[6:0];
          end
          LTR_RATE: begin
            pend_rate_vld_reg <= 1'b1;
            pend_rate_reg <= I_CMD.value[1:0];
          end
          LTR_VALUE: begin
            pend_v_vld_reg <= 1'b1;
            pend_v_reg <= I_CMD.value;
          end
          default: begin
            // Letters owned by other blocks pass by
          end
        endcase
      end
    end
  end

  // Range and rate settings
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      set_reg.range <= RANGE_AUTO;
      set_reg.autorange <= 1'b1;
      set_reg.rate <= RATE_DEFAULT;
    end else if (I_DEV_CLEAR) begin
      set_reg.range <= RANGE_AUTO;
      set_reg.autorange <= 1'b1;
      set_reg.rate <= RATE_DEFAULT;
    end else if (apply) begin
      if (pend_range_vld_reg) begin
        set_reg.range <= pend_range_reg;
        set_reg.autorange <= pend_range_reg == RANGE_AUTO;
      end
      if (pend_rate_vld_reg) begin
        set_reg.rate <= pend_rate_reg;
      end
    end
  end

  // Ready drops on a range change and returns on front end completion
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      ready_reg <= 1'b1;
    end else if (I_DEV_CLEAR) begin
      ready_reg <= 1'b1;
    end else if (apply && pend_range_vld_reg) begin
      ready_reg <= 1'b0; // New change wins over a stale done
    end else if (I_RANGE_DONE) begin
      ready_reg <= 1'b1;
    end
  end

  // Zero mode, offset and zero slot
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      set_reg.zero_mode <= ZERO_OFF;
      offset_reg <= 32'sh0000_0000;
      v_set_reg <= 1'b0;
      zero_ref_reg <= 32'sh0000_0000;
      O_ZERO_SLOT <= 32'sh0000_0000;
    end else if (I_DEV_CLEAR) begin
      set_reg.zero_mode <= ZERO_OFF;
      offset_reg <= 32'sh0000_0000;
      v_set_reg <= 1'b0;
      zero_ref_reg <= 32'sh0000_0000;
    end else if (apply) begin
      offset_reg <= new_offset;
      v_set_reg <= new_v_set;
      if (pend_zero_vld_reg) begin
        if (pend_zero_reg == ZERO_OFF) begin
          set_reg.zero_mode <= ZERO_OFF;
        end else if (pend_zero_reg == ZERO_PROG && new_v_set) begin
          set_reg.zero_mode <= ZERO_PROG;
          zero_ref_reg <= new_offset;
          O_ZERO_SLOT <= new_offset;
        end else begin
          // Code 1, or code 2 with nothing programmed
          set_reg.zero_mode <= ZERO_BASE;
          zero_ref_reg <= present_rd;
          O_ZERO_SLOT <= present_rd;
        end
      end
    end
  end

  // Filter enable; the count itself lives per function in memory
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      set_reg.filt_on <= 1'b0;
    end else if (I_DEV_CLEAR) begin
      set_reg.filt_on <= 1'b0;
    end else if (apply && pend_filt_vld_reg) begin
      set_reg.filt_on <= pend_filt_reg != 7'h00;
    end
  end

  // A nonzero filter code overwrites the active function's count
  assign filt_wr = apply && pend_filt_vld_reg && pend_filt_reg != 7'h00;

  // Filter counts per function; read follows the active function
  msc_filter_mem u_filt_mem (
    .clk(I_REF_CLK),
    .rst(I_RST),
    .clr(I_DEV_CLEAR),
    .wr_en(filt_wr),
    .wr_addr(I_FUNC),
    .wr_data(pend_filt_reg),
    .rd_addr(I_FUNC),
    .rd_data(O_FILT_CNT)
  );

  // Resolution and integration period from rate, function and range
  msc_rate_table #(
    .C35(INT_35_CYCLES),
    .C45(INT_45_CYCLES),
    .C50(INT_50HZ_CYCLES),
    .C60(INT_60HZ_CYCLES)
  ) u_rate (
    .clk(I_REF_CLK),
    .rst(I_RST),
    .rate(set_reg.rate),
    .func(I_FUNC),
    .range(set_reg.range),
    .line_60hz(I_LINE_60HZ),
    .res(O_RESOLUTION),
    .int_cycles(O_INT_CYCLES)
  );

  // Command error: set by a rejected execute, cleared by a clean one
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      cmd_err_reg <= 1'b0;
    end else if (I_DEV_CLEAR) begin
      cmd_err_reg <= 1'b0;
    end else if (is_exec) begin
      cmd_err_reg <= pend_err_reg; // Old settings kept
    end
  end

  // Bus error pulse when a command arrives without remote enable
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      bus_err_reg <= 1'b0;
    end else begin
      bus_err_reg <= I_CMD.valid && !I_REMOTE_EN;
    end
  end

  // Latest input, kept so a baseline can be caught between samples
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      last_rd_reg <= 32'sh0000_0000;
    end else if (I_READING_VALID) begin
      last_rd_reg <= I_READING;
    end
  end

  // Reported reading relative to the zero reference while zero is on.
  // Wraps on overflow; the front end never spans the full 32 bits.
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      rd_out_reg <= 32'sh0000_0000;
      rd_vld_reg <= 1'b0;
    end else begin
      rd_vld_reg <= I_READING_VALID;
      if (I_READING_VALID) begin
        if (set_reg.zero_mode != ZERO_OFF) begin
          rd_out_reg <= I_READING - zero_ref_reg;
        end else begin
          rd_out_reg <= I_READING;
        end
      end
    end
  end

  // Outputs straight from registers
  assign O_SETTINGS = set_reg;
  assign O_READY = ready_reg;
  assign O_CMD_ERR = cmd_err_reg;
  assign O_BUS_ERR = bus_err_reg;
  assign O_READING = rd_out_reg;
  assign O_READING_VALID = rd_vld_reg;
endmodule

// ==== sim/msc_chk.sv ====
// Port-level checker for the setting decoder, bound to its top module.
// Assumes the period parameters are handed on by the bind below.
module msc_chk #(
  parameter int INT_35_CYCLES = 5,
  parameter int INT_45_CYCLES = 7,
  parameter int INT_50HZ_CYCLES = 11,
  parameter int INT_60HZ_CYCLES = 13
)
(
  // Clock, reset and bus side
  input wire logic I_REF_CLK,
  input wire logic I_RST,
  input wire msc_pkg::msc_cmd_type I_CMD,
  input wire logic I_REMOTE_EN,
  input wire logic I_DEV_CLEAR,
  // Measurement context
  input wire logic [2:0] I_FUNC,
  input wire logic I_LINE_60HZ,
  input wire logic I_RANGE_DONE,
  input wire logic signed [31:0] I_READING,
  input wire logic I_READING_VALID,
  // Design outputs
  input wire msc_pkg::msc_set_type O_SETTINGS,
  input wire logic [6:0] O_FILT_CNT,
  input wire msc_pkg::msc_res_type O_RESOLUTION,
  input wire logic [msc_pkg::INT_W-1:0] O_INT_CYCLES,
  input wire logic signed [31:0] O_ZERO_SLOT,
  input wire logic O_READY,
  input wire logic O_CMD_ERR,
  input wire logic O_BUS_ERR,
  input wire logic signed [31:0] O_READING,
  input wire logic O_READING_VALID
);
  timeunit 1ns;
  timeprecision 1ps;
  import msc_pkg::*;
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (I_RST);
  // Low until one edge after reset, so history never holds reset values
  logic live_reg;
  always_ff @(posedge I_REF_CLK or posedge I_RST) begin
    if (I_RST) begin
      live_reg <= 1'b0;
    end else begin
      live_reg <= 1'b1;
    end
  end
  // Expected integration period for a resolution
  function automatic logic [INT_W-1:0] period(input msc_res_type r, input logic hz60);
    return r == RES_35 ? INT_W'(INT_35_CYCLES) : r == RES_45 ? INT_W'(INT_45_CYCLES) :
      hz60 ? INT_W'(INT_60HZ_CYCLES) : INT_W'(INT_50HZ_CYCLES);
  endfunction
  // Execute character taken
  sequence s_exec;
    I_CMD.valid && I_REMOTE_EN && !I_DEV_CLEAR && I_CMD.letter == LTR_EXEC;
  endsequence
  // Command seen without remote enable
  sequence s_no_ren;
    I_CMD.valid && !I_REMOTE_EN && !I_DEV_CLEAR;
  endsequence
  AST_BUS_ERR_SET: assert property (s_no_ren |=> O_BUS_ERR)
    else $error("bus error missing after command without remote enable");
  AST_BUS_ERR_QUIET: assert property (!I_CMD.valid |=> !O_BUS_ERR)
    else $error("bus error without a command");
  AST_AUTO_FLAG: assert property (
    O_SETTINGS.autorange == (O_SETTINGS.range == RANGE_AUTO))
    else $error("autorange flag disagrees with range code");
  AST_APPLY_AT_EXEC: assert property (live_reg && $changed(O_SETTINGS) |->
    $past(I_CMD.valid && I_REMOTE_EN && I_CMD.letter == LTR_EXEC) || $past(I_DEV_CLEAR))
    else $error("settings changed without execute");
  AST_READY_HOLD: assert property (!O_READY && !I_RANGE_DONE && !I_DEV_CLEAR |=> !O_READY)
    else $error("ready before range change completed");
  AST_READY_DROP: assert property ($fell(O_READY) |->
    $past(I_CMD.valid && I_CMD.letter == LTR_EXEC))
    else $error("ready dropped without execute");
  AST_CLEAR: assert property (I_DEV_CLEAR |=> O_READY && !O_CMD_ERR &&
    O_SETTINGS == {RANGE_AUTO, 1'b1, ZERO_OFF, 1'b0, RATE_DEFAULT})
    else $error("device clear did not restore defaults");
  AST_CLEAR_FILT: assert property (I_DEV_CLEAR ##1 !I_CMD.valid |=>
    O_FILT_CNT == FILT_CNT_DEFAULT)
    else $error("filter count not default after clear");
  AST_READ_PASS: assert property (I_READING_VALID &&
    O_SETTINGS.zero_mode == ZERO_OFF |=> O_READING_VALID && O_READING == $past(I_READING))
    else $error("reading altered with zero off");
  AST_RES_FOLLOW: assert property (live_reg && $past(I_FUNC) <= 3'h1 |->
    O_RESOLUTION == msc_res_type'($past(O_SETTINGS.rate)))
    else $error("voltage resolution does not follow rate");
  AST_INT_PERIOD: assert property (live_reg && $stable(I_LINE_60HZ) |->
    O_INT_CYCLES == period(O_RESOLUTION, I_LINE_60HZ))
    else $error("integration period does not match resolution");
  AST_ERR_AT_EXEC: assert property (
    !(I_CMD.valid && I_CMD.letter == LTR_EXEC) && !I_DEV_CLEAR |=> $stable(O_CMD_ERR))
    else $error("command error changed outside execute");
  // An execute with nothing buffered behind another is always clean
  AST_EXEC_CLEAN: assert property (s_exec ##1 s_exec |=> !O_CMD_ERR)
    else $error("command error after an empty execute");
endmodule
bind msc_decoder msc_chk #(
  .INT_35_CYCLES(INT_35_CYCLES),
  .INT_45_CYCLES(INT_45_CYCLES),
  .INT_50HZ_CYCLES(INT_50HZ_CYCLES),
  .INT_60HZ_CYCLES(INT_60HZ_CYCLES)
) msc_chk_inst (.I_REF_CLK, .I_RST, .I_CMD, .I_REMOTE_EN, .I_DEV_CLEAR, .I_FUNC, .I_LINE_60HZ,
  .I_RANGE_DONE, .I_READING, .I_READING_VALID, .O_SETTINGS, .O_FILT_CNT, .O_RESOLUTION,
  .O_INT_CYCLES, .O_ZERO_SLOT, .O_READY, .O_CMD_ERR, .O_BUS_ERR, .O_READING, .O_READING_VALID);

// ==== sim/msc_ctrl_model.sv ====
// Bus controller model sending parsed setting commands to the decoder.
// Assumes it shares the decoder's clock; tasks drive just after an edge.
module msc_ctrl_model (
  // Clock
  input wire logic i_clk,
  // Command side
  output msc_pkg::msc_cmd_type o_cmd,
  output logic o_remote_en,
  output logic o_dev_clear
);
  timeunit 1ns;
  timeprecision 1ps;
  import msc_pkg::*;
  // Idle bus, remote enable asserted
  initial begin
    o_cmd = '0;
    o_remote_en = 1'b1;
    o_dev_clear = 1'b0;
  end
  // One command; the last of a string is released after it is taken
  task automatic put(input logic [7:0] l, input logic signed [31:0] v, input logic last);
    @(posedge i_clk);
    o_cmd <= '{valid: 1'b1, letter: l, value: v};
    if (last) begin
      @(posedge i_clk);
      // Released lines carry a changed pattern, never the old value
      o_cmd <= '{valid: 1'b0, letter: ~l, value: ~v};
    end
  endtask
  // Remote enable level
  task automatic set_ren(input logic b);
    @(posedge i_clk);
    o_remote_en <= b;
  endtask
  // Device clear pulse of one cycle
  task automatic clear();
    @(posedge i_clk);
    o_dev_clear <= 1'b1;
    @(posedge i_clk);
    o_dev_clear <= 1'b0;
  endtask
endmodule

// ==== sim/testbench.sv ====
// Self-checking bench for the setting decoder with a controller model.
// Assumes short integration counts set through the design parameters.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import msc_pkg::*;
  // Shortened periods keep the run brief
  localparam int C35 = 5;
  localparam int C45 = 7;
  localparam int C50 = 11;
  localparam int C60 = 13;
  logic ref_clk = 1'b0;
  logic rst, line_60hz, range_done, reading_valid, ready, cmd_err, bus_err, rd_out_valid;
  logic [2:0] func;
  logic signed [31:0] reading, zero_slot, rd_out;
  logic [6:0] filt_cnt;
  logic [INT_W-1:0] int_cycles;
  msc_cmd_type cmd;
  logic ren, dclr;
  msc_set_type settings;
  msc_res_type res;
  int miscompares = 0;
  int checked = 0;
  always #5 ref_clk = ~ref_clk;
  msc_ctrl_model msc_ctrl_model_inst (.i_clk(ref_clk), .o_cmd(cmd), .o_remote_en(ren),
    .o_dev_clear(dclr));
  msc_decoder #(.INT_35_CYCLES(C35), .INT_45_CYCLES(C45), .INT_50HZ_CYCLES(C50),
    .INT_60HZ_CYCLES(C60)) msc_decoder_inst (.I_REF_CLK(ref_clk), .I_RST(rst), .I_CMD(cmd),
    .I_REMOTE_EN(ren), .I_DEV_CLEAR(dclr), .I_FUNC(func), .I_LINE_60HZ(line_60hz),
    .I_RANGE_DONE(range_done), .I_READING(reading), .I_READING_VALID(reading_valid),
    .O_SETTINGS(settings), .O_FILT_CNT(filt_cnt), .O_RESOLUTION(res),
    .O_INT_CYCLES(int_cycles), .O_ZERO_SLOT(zero_slot), .O_READY(ready), .O_CMD_ERR(cmd_err),
    .O_BUS_ERR(bus_err), .O_READING(rd_out), .O_READING_VALID(rd_out_valid));
  // Compare and count
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Verdict and end of run
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // Let one edge land, then sample
  task automatic settle();
    @(posedge ref_clk);
    #1;
  endtask
  // One command followed by execute
  task automatic run1(input logic [7:0] l, input logic signed [31:0] v);
    msc_ctrl_model_inst.put(l, v, 1'b0);
    msc_ctrl_model_inst.put(LTR_EXEC, 32'sh0, 1'b1);
    settle();
  endtask
  task automatic set_func(input logic [2:0] f);
    @(posedge ref_clk);
    func <= f;
    settle();
  endtask
  task automatic pulse_done();
    @(posedge ref_clk);
    range_done <= 1'b1;
    @(posedge ref_clk);
    range_done <= 1'b0;
    #1;
  endtask
  // Sample in, corrected value out one cycle later
  task automatic sample(input logic signed [31:0] v, input logic signed [31:0] exp);
    @(posedge ref_clk);
    reading <= v;
    reading_valid <= 1'b1;
    @(posedge ref_clk);
    reading_valid <= 1'b0;
    reading <= ~v;
    #1;
    check("reading", rd_out, exp);
    check("reading valid", 32'(rd_out_valid), 32'h1);
  endtask
  function automatic msc_set_type exp_set(input logic [2:0] r, input logic [1:0] z,
    input logic f, input logic [1:0] s);
    return '{range: r, autorange: r == RANGE_AUTO, zero_mode: z, filt_on: f, rate: s};
  endfunction
  // Hang guard
  initial begin
    repeat (20000) @(posedge ref_clk);
    miscompares++;
    tally_and_finish();
  end
  // Main sequence
  initial begin
    rst = 1'b1;
    func = 3'h0;
    line_60hz = 1'b0;
    range_done = 1'b0;
    reading = 32'sh0;
    reading_valid = 1'b0;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    settle();
    check("settings", 32'(settings),
      32'(exp_set(RANGE_AUTO, ZERO_OFF, 1'b0, RATE_DEFAULT)));
    check("filter count", 32'(filt_cnt), 32'(FILT_CNT_DEFAULT));
    check("period", 32'(int_cycles), 32'(C50));
    // Every range code, fixed codes leave autorange
    for (int n = 7; n >= 0; n--) begin
      run1(LTR_RANGE, n);
      check("range", 32'(settings.range), 32'(n));
      check("ready low", 32'(ready), 32'h0);
      pulse_done();
      check("ready", 32'(ready), 32'h1);
    end
    run1(LTR_RANGE, 8);
    check("bad range error", 32'(cmd_err), 32'h1);
    // Buffered until execute; a bad code discards the string
    msc_ctrl_model_inst.put(LTR_RANGE, 5, 1'b1);
    settle();
    check("range held", 32'(settings.range), 32'h0);
    run1(LTR_EXEC, 0);
    check("range applied", 32'(settings.range), 32'h5);
    pulse_done();
    msc_ctrl_model_inst.put(LTR_RANGE, 2, 1'b0);
    run1(LTR_ZERO, 5);
    check("string discarded", 32'(settings),
      32'(exp_set(3'h5, ZERO_OFF, 1'b0, 2'h3)));
    msc_ctrl_model_inst.set_ren(1'b0);
    msc_ctrl_model_inst.put(LTR_FILT, 7, 1'b1);
    #1;
    check("bus error", 32'(bus_err), 32'h1);
    run1(LTR_RANGE, 1);
    check("no remote", 32'(settings.range), 32'h5);
    check("bus error end", 32'(bus_err), 32'h0);
    msc_ctrl_model_inst.set_ren(1'b1);
    // Every rate on both mains frequencies
    for (int k = 0; k < 8; k++) begin
      @(posedge ref_clk);
      line_60hz <= k[0];
      run1(LTR_RATE, k / 2);
      check("resolution", 32'(res), 32'(k / 2));
      check("period", 32'(int_cycles), 32'(k < 2 ? C35 : k < 4 ? C45 : k[0] ? C60 : C50));
    end
    set_func(3'h3);
    check("current resolution", 32'(res), 32'(RES_55));
    // Filter counts kept per function
    set_func(3'h2);
    run1(LTR_FILT, 20);
    check("filter count", 32'(filt_cnt), 32'd20);
    set_func(3'h5);
    check("other function count", 32'(filt_cnt), 32'(FILT_CNT_DEFAULT));
    set_func(3'h2);
    run1(LTR_FILT, 99);
    run1(LTR_FILT, 100);
    check("filter range error", 32'(cmd_err), 32'h1);
    run1(LTR_FILT, 0);
    check("filter off", 32'({settings.filt_on, filt_cnt}), 32'd99);
    // Zero modes
    sample(500, 500);
    run1(LTR_ZERO, 1);
    check("baseline slot", zero_slot, 32'sd500);
    sample(700, 200);
    run1(LTR_VALUE, 2000);
    run1(LTR_ZERO, 2);
    check("zero mode", 32'(settings.zero_mode), 32'(ZERO_PROG));
    check("offset slot", zero_slot, 32'sd2000);
    sample(500, -1500);
    run1(LTR_ZERO, 0);
    sample(500, 500);
    // Clear drops the offset, so code 2 then acts as code 1
    msc_ctrl_model_inst.clear();
    settle();
    check("cleared", 32'({filt_cnt, settings}),
      {16'h0, FILT_CNT_DEFAULT, exp_set(RANGE_AUTO, ZERO_OFF, 1'b0, RATE_DEFAULT)});
    sample(300, 300);
    run1(LTR_ZERO, 2);
    check("code 2 as 1", 32'(settings.zero_mode), 32'(ZERO_BASE));
    sample(400, 100);
    tally_and_finish();
  end
endmodule
